/* rtl/dmd_display.sv */
/*
  Drive monitor display select: slot sequencing, frequency display rules,
  terminal monitor segment map, hour counters and cumulative energy.
  Assumes all inputs synchronous to clock_in; clear writes are one-cycle
  strobes with the written value alongside.
*/
`timescale 1ns/100ps
`include "dmd_consts.svh"
module dmd_display #(
  parameter int SEC_CYC  = `DMD_SEC_NS / `DMD_CLK_NS,
  parameter int HOLD_CYC = SEC_CYC * `DMD_HOLD_S
) (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  // Settings
  input  wire logic [15:0]       monitor_select_in,
  input  wire logic [15:0]       energy_digit_shift_in,
  input  wire logic              energy_clear_wr_in,
  input  wire logic [15:0]       energy_clear_in,
  input  wire logic              runtime_clear_wr_in,
  input  wire logic [15:0]       runtime_clear_in,
  // Drive state
  input  wire logic              set_key_in,
  input  wire logic              running_in,
  input  wire logic              fault_in,
  input  wire logic              output_shutoff_in,
  input  wire dmd_pkg::dmd_meas_t meas_in,
  input  wire dmd_pkg::dmd_term_t term_in,
  // Display and monitors
  output dmd_pkg::dmd_disp_t     front_panel_out,
  output dmd_pkg::dmd_slot_t     slot_out,
  output logic [15:0]            current_mon_out,
  output logic [15:0]            power_mon_out,
  output logic [15:0]            powered_hours_out,
  output logic [15:0]            run_hours_out,
  output logic [39:0]            energy_raw_out,
  output logic [15:0]            energy_comm_out
);
  import dmd_pkg::*;

  function automatic logic [39:0] pow10(input logic [15:0] s);
    logic [39:0] p;
    p = 40'h1;
    for (int i = 0; i < 4; i++) begin
      if (i < s && s <= `DMD_SHIFT_MAX) begin
        p = p * 40'd10;
      end
    end
    return p;
  endfunction : pow10

  // Key, slot and first monitor
  dmd_key_t    key_r, key_nxt;
  dmd_slot_t   slot_r, slot_nxt;
  dmd_slot_t   first_r, first_nxt;
  logic [31:0] hold_r, hold_nxt;

  always_comb begin
    key_nxt   = key_r;
    slot_nxt  = slot_r;
    first_nxt = first_r;
    hold_nxt  = hold_r;
    case (key_r)
      KEY_IDLE: begin
        hold_nxt = 32'h0;
        if (set_key_in) begin
          key_nxt = KEY_DOWN;
        end
      end
      KEY_DOWN: begin
        if (!set_key_in) begin
          slot_nxt = dmd_slot_t'(slot_r + 2'h1);
          key_nxt  = KEY_IDLE;
        end else if (hold_r == 32'(HOLD_CYC - 1)) begin
          first_nxt = slot_r;
          key_nxt   = KEY_LONG;
        end else begin
          hold_nxt = hold_r + 32'h1;
        end
      end
      KEY_LONG: begin
        if (!set_key_in) begin
          key_nxt = KEY_IDLE;
        end
      end
      default: key_nxt = KEY_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      key_r   <= KEY_IDLE;
      slot_r  <= SLOT_FREQ;
      first_r <= SLOT_FREQ;
      hold_r  <= 32'h0;
    end else begin
      key_r   <= key_nxt;
      slot_r  <= slot_nxt;
      first_r <= first_nxt;
      hold_r  <= hold_nxt;
    end
  end

  // Fault frequency capture
  logic        fault_d_r, fault_d_nxt;
  logic [15:0] flt_freq_r, flt_freq_nxt;

  always_comb begin
    fault_d_nxt  = fault_in;
    flt_freq_nxt = flt_freq_r;
    if (fault_in && !fault_d_r) begin
      flt_freq_nxt = meas_in.out_freq;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fault_d_r  <= 1'b0;
      flt_freq_r <= 16'h0;
    end else begin
      fault_d_r  <= fault_d_nxt;
      flt_freq_r <= flt_freq_nxt;
    end
  end

  // Hour prescalers and counters
  logic [31:0] pcyc_r, pcyc_nxt, rcyc_r, rcyc_nxt;
  logic [11:0] psec_r, psec_nxt, rsec_r, rsec_nxt;
  logic [15:0] phr_r, phr_nxt, rhr_r, rhr_nxt;
  logic        sec_tick, hour_tick;

  always_comb begin
    pcyc_nxt  = pcyc_r + 32'h1;
    psec_nxt  = psec_r;
    rcyc_nxt  = rcyc_r;
    rsec_nxt  = rsec_r;
    phr_nxt   = phr_r;
    rhr_nxt   = rhr_r;
    sec_tick  = 1'b0;
    hour_tick = 1'b0;
    if (pcyc_r == 32'(SEC_CYC - 1)) begin
      pcyc_nxt = 32'h0;
      sec_tick = 1'b1;
      psec_nxt = psec_r + 12'h1;
      if (psec_r == 12'(`DMD_HOUR_S - 1)) begin
        psec_nxt  = 12'h0;
        hour_tick = 1'b1;
        phr_nxt   = phr_r + 16'h1;
      end
    end
    if (running_in) begin
      rcyc_nxt = rcyc_r + 32'h1;
      if (rcyc_r == 32'(SEC_CYC - 1)) begin
        rcyc_nxt = 32'h0;
        rsec_nxt = rsec_r + 12'h1;
        if (rsec_r == 12'(`DMD_HOUR_S - 1)) begin
          rsec_nxt = 12'h0;
          rhr_nxt  = rhr_r + 16'h1;
        end
      end
    end
    if (runtime_clear_wr_in && runtime_clear_in == 16'h0) begin
      rhr_nxt  = 16'h0;
      rcyc_nxt = 32'h0;
      rsec_nxt = 12'h0;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pcyc_r <= 32'h0;
      rcyc_r <= 32'h0;
      psec_r <= 12'h0;
      rsec_r <= 12'h0;
      phr_r  <= 16'h0;
      rhr_r  <= 16'h0;
    end else begin
      pcyc_r <= pcyc_nxt;
      rcyc_r <= rcyc_nxt;
      psec_r <= psec_nxt;
      rsec_r <= rsec_nxt;
      phr_r  <= phr_nxt;
      rhr_r  <= rhr_nxt;
    end
  end

  // Low current cut-off
  logic [15:0] cur_mon, pow_mon;
  always_comb begin
    cur_mon = meas_in.current;
    pow_mon = meas_in.power;
    if (32'(meas_in.current) * 32'd100 < 32'(meas_in.rated) * 32'(`DMD_CUR_PCT)) begin
      cur_mon = 16'h0;
      pow_mon = 16'h0;
    end
  end

  // Cumulative energy, kept in 0.01 kWh
  logic [39:0] eacc_r, eacc_nxt, eraw_r, eraw_nxt;
  logic [39:0] e_sum, e_shift, e_div;
  logic        e_wrap;

  always_comb begin
    e_wrap   = energy_digit_shift_in > `DMD_SHIFT_MAX;
    e_div    = pow10(energy_digit_shift_in);
    eacc_nxt = eacc_r;
    eraw_nxt = eraw_r;
    if (sec_tick) begin
      eacc_nxt = eacc_r + 40'(pow_mon);
    end
    e_sum    = eraw_r + eacc_nxt / 40'(`DMD_HOUR_S);
    if (hour_tick) begin
      eacc_nxt = eacc_nxt % 40'(`DMD_HOUR_S);
      eraw_nxt = e_sum;
      if (e_sum / e_div > `DMD_E_MAX) begin
        eraw_nxt = e_wrap ? 40'h0 : (`DMD_E_MAX + 40'h1) * e_div - 40'h1;
      end
    end
    if (energy_clear_wr_in && energy_clear_in == 16'h0) begin
      eraw_nxt = 40'h0;
      eacc_nxt = 40'h0;
    end
    e_shift = eraw_r / e_div;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      eacc_r <= 40'h0;
      eraw_r <= 40'h0;
    end else begin
      eacc_r <= eacc_nxt;
      eraw_r <= eraw_nxt;
    end
  end

  // Terminal segment map: a,b,f upper; c,d,e lower; g centre
  logic [11:0] up_bits, lo_bits;
  logic [27:0] seg_map;

  always_comb begin
    up_bits = 12'h0;
    lo_bits = 12'h0;
    case (monitor_select_in)
      `DMD_SEL_TUNIT: begin
        up_bits = term_in.unit_in;
        lo_bits = term_in.unit_out;
      end
      `DMD_SEL_TOPTIN:  up_bits = term_in.opt_in_fit ? term_in.opt_in : 12'h0;
      `DMD_SEL_TOPTOUT: lo_bits = term_in.opt_out_fit ? term_in.opt_out : 12'h0;
      default:          up_bits = 12'h0;
    endcase
  end

  for (genvar d = 0; d < 4; d++) begin : g_digit
    assign seg_map[7*d+0] = up_bits[3*d+0];
    assign seg_map[7*d+1] = up_bits[3*d+1];
    assign seg_map[7*d+5] = up_bits[3*d+2];
    assign seg_map[7*d+2] = lo_bits[3*d+0];
    assign seg_map[7*d+3] = lo_bits[3*d+1];
    assign seg_map[7*d+4] = lo_bits[3*d+2];
    assign seg_map[7*d+6] = 1'b1;
  end

  // Display composition
  dmd_disp_t   disp_r, disp_nxt;
  logic [15:0] comm_r, comm_nxt;
  logic [31:0] val;
  logic        stopped, is_term, load_sel;

  always_comb begin
    disp_nxt = '0;
    val      = 32'h0;
    stopped  = !running_in || output_shutoff_in;
    is_term  = monitor_select_in >= `DMD_SEL_TUNIT &&
               monitor_select_in <= `DMD_SEL_TOPTOUT;
    load_sel = monitor_select_in == `DMD_SEL_LOADM ||
               monitor_select_in == `DMD_SEL_LOADF;
    comm_nxt = e_shift / 40'd100 > 40'hffff ? 16'hffff : 16'(e_shift / 40'd100);
    case (slot_r)
      SLOT_FREQ: begin
        disp_nxt.hz_on = 1'b1;
        val = 32'(meas_in.out_freq);
        if (fault_in) begin
          val = 32'(flt_freq_nxt);
        end else if (monitor_select_in == `DMD_SEL_STOPSET && stopped) begin
          val = 32'(meas_in.set_freq);
          disp_nxt.hz_on    = 1'b0;
          disp_nxt.hz_blink = 1'b1;
        end
      end
      SLOT_CUR: begin
        val = 32'(cur_mon);
        if (monitor_select_in == `DMD_SEL_LOADM) begin
          val = 32'(meas_in.load_meter);
        end else if (monitor_select_in == `DMD_SEL_LOADF) begin
          val = 32'(meas_in.load_factor);
        end
      end
      SLOT_VOLT: begin
        val = 32'(meas_in.volt);
        if (monitor_select_in != `DMD_SEL_CYCLE && !load_sel &&
            monitor_select_in != `DMD_SEL_STOPSET) begin
          val = 32'(meas_in.aux);
          case (monitor_select_in)
            `DMD_SEL_REF:   val = 32'(meas_in.ref_freq);
            `DMD_SEL_POWER: val = 32'(pow_mon);
            `DMD_SEL_PWRHR: begin
              val         = 32'(phr_r / 16'(`DMD_HR_SCALE));
              disp_nxt.dp = `DMD_DP_DIG2;
            end
            `DMD_SEL_RUNHR: begin
              val         = 32'(rhr_r / 16'(`DMD_HR_SCALE));
              disp_nxt.dp = `DMD_DP_DIG2;
            end
            `DMD_SEL_ENERGY: begin
              if (e_shift < `DMD_E_2DEC) begin
                val         = 32'(e_shift);
                disp_nxt.dp = `DMD_DP_DIG2;
              end else if (e_shift < `DMD_E_1DEC) begin
                val         = 32'(e_shift / 40'd10);
                disp_nxt.dp = `DMD_DP_DIG3;
              end else begin
                val = 32'(e_shift / 40'd100);
              end
            end
            `DMD_SEL_TOPTIN:  disp_nxt.dp = `DMD_DP_DIG1;
            `DMD_SEL_TOPTOUT: disp_nxt.dp = `DMD_DP_DIG2;
            default: val = 32'(meas_in.aux);
          endcase
          if (is_term) begin
            val               = 32'h0;
            disp_nxt.seg_mode = 1'b1;
            disp_nxt.seg      = seg_map;
          end
        end
      end
      SLOT_FAULT: begin
        val = 32'(meas_in.fault_code);
      end
      default: val = 32'h0;
    endcase
    if (val > `DMD_PANEL_MAX) begin
      disp_nxt.dashes = 1'b1;
      disp_nxt.dp     = 4'h0;
      val             = 32'h0;
    end
    disp_nxt.value = val[15:0];
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      disp_r <= '0;
      comm_r <= 16'h0;
    end else begin
      disp_r <= disp_nxt;
      comm_r <= comm_nxt;
    end
  end

  assign front_panel_out   = disp_r;
  assign slot_out          = slot_r;
  assign current_mon_out   = cur_mon;
  assign power_mon_out     = pow_mon;
  assign powered_hours_out = phr_r;
  assign run_hours_out     = rhr_r;
  assign energy_raw_out    = eraw_r;
  assign energy_comm_out   = comm_r;
endmodule : dmd_display

/* rtl/dmd_consts.svh */
/*
  Constants of the drive monitor display select block: offsets of nothing
  (no register bus), field positions, select codes, limits and timing counts.
  Assumes a 250 MHz system clock and one inclusion per compilation unit.
*/
`ifndef DMD_CONSTS_SVH
`define DMD_CONSTS_SVH
`define DMD_CLK_NS      4
`define DMD_SEC_NS      1000000000
`define DMD_HOLD_S      1
`define DMD_HOUR_S      3600
`define DMD_SEL_CYCLE   16'h0000
`define DMD_SEL_REF     16'h0005
`define DMD_SEL_POWER   16'h000e
`define DMD_SEL_LOADM   16'h0011
`define DMD_SEL_PWRHR   16'h0014
`define DMD_SEL_RUNHR   16'h0017
`define DMD_SEL_LOADF   16'h0018
`define DMD_SEL_ENERGY  16'h0019
`define DMD_SEL_TUNIT   16'h0037
`define DMD_SEL_TOPTIN  16'h0038
`define DMD_SEL_TOPTOUT 16'h0039
`define DMD_SEL_STOPSET 16'h0064
`define DMD_SHIFT_WRAP  16'h270f
`define DMD_SHIFT_MAX   16'h0004
`define DMD_PANEL_MAX   32'd9999
`define DMD_E_MAX       40'd999999
`define DMD_E_2DEC      40'd10000
`define DMD_E_1DEC      40'd100000
`define DMD_CUR_PCT     5
`define DMD_HR_SCALE    10
`define DMD_DP_DIG1     4'h8
`define DMD_DP_DIG2     4'h4
`define DMD_DP_DIG3     4'h2
`endif

/* rtl/dmd_pkg.sv */
/*
  Types of the drive monitor display select block.
  Assumes the constants header is compiled alongside.
*/
package dmd_pkg;
  typedef enum logic [1:0] {SLOT_FREQ, SLOT_CUR, SLOT_VOLT, SLOT_FAULT} dmd_slot_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_DOWN, KEY_LONG} dmd_key_t;
  // Measured values, already in panel counts
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] set_freq;
    logic [15:0] ref_freq;
    logic [15:0] volt;
    logic [15:0] current;
    logic [15:0] rated;
    logic [15:0] power;
    logic [15:0] load_meter;
    logic [15:0] load_factor;
    logic [15:0] aux;
    logic [15:0] fault_code;
  } dmd_meas_t;
  typedef struct packed {
    logic [11:0] unit_in;
    logic [11:0] unit_out;
    logic [11:0] opt_in;
    logic [11:0] opt_out;
    logic        opt_in_fit;
    logic        opt_out_fit;
  } dmd_term_t;
  // Panel image: value, decimal points (bit 3 = first digit), segments
  typedef struct packed {
    logic [15:0] value;
    logic [3:0]  dp;
    logic        dashes;
    logic        seg_mode;
    logic [27:0] seg;
    logic        hz_on;
    logic        hz_blink;
  } dmd_disp_t;
endpackage : dmd_pkg

/* test/dmd_display_checker.sv */
/*
  Port assertions for the monitor display select block.
  Assumes it is bound into dmd_display and sees only that module's ports.
*/
`timescale 1ns/100ps
module dmd_display_checker
  import dmd_pkg::*;
#(
  parameter int SEC_CYC  = 10,
  parameter int HOLD_CYC = 5
) (
  // Clock, reset and settings
  input wire logic              clock_in,
  input wire logic              nrst_in,
  input wire logic [15:0]       monitor_select_in,
  input wire logic [15:0]       energy_digit_shift_in,
  input wire logic              energy_clear_wr_in,
  input wire logic [15:0]       energy_clear_in,
  input wire logic              runtime_clear_wr_in,
  input wire logic [15:0]       runtime_clear_in,
  // Drive state
  input wire logic              running_in,
  input wire logic              fault_in,
  input wire logic              output_shutoff_in,
  input wire dmd_pkg::dmd_meas_t meas_in,
  input wire dmd_pkg::dmd_term_t term_in,
  // Outputs watched
  input wire dmd_pkg::dmd_disp_t front_panel_out,
  input wire dmd_pkg::dmd_slot_t slot_out,
  input wire logic [15:0]       current_mon_out,
  input wire logic [15:0]       power_mon_out,
  input wire logic [15:0]       powered_hours_out,
  input wire logic [15:0]       run_hours_out,
  input wire logic [39:0]       energy_raw_out
);
  localparam logic [27:0] G_SEGS = 28'h8102040;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  a_cut_current: assert property (current_mon_out == ((32'(meas_in.current) * 32'd20 < 32'(meas_in.rated))
    ? 16'h0000 : meas_in.current)) else $error("current cut-off wrong");
  a_cut_power: assert property (current_mon_out == 16'h0000 |-> power_mon_out == 16'h0000)
    else $error("power shown with current cut off");
  a_panel_range: assert property (front_panel_out.value <= 16'd9999) else $error("panel value too wide");
  a_centre_lit: assert property (front_panel_out.seg_mode |-> (front_panel_out.seg & G_SEGS) == G_SEGS)
    else $error("centre segment dark");
  a_opt_in_dp: assert property ($past(monitor_select_in) == 16'h0038 && $past(slot_out) == SLOT_VOLT
    |-> front_panel_out.dp == 4'h8 && front_panel_out.seg_mode) else $error("input option point wrong");
  a_opt_out_dp: assert property ($past(monitor_select_in) == 16'h0039 && $past(slot_out) == SLOT_VOLT
    |-> front_panel_out.dp == 4'h4 && front_panel_out.seg_mode) else $error("output option point wrong");
  a_opt_absent: assert property ($past(monitor_select_in) == 16'h0039 && !$past(term_in.opt_out_fit)
    && $past(slot_out) == SLOT_VOLT |-> front_panel_out.seg == G_SEGS) else $error("absent option lit");
  a_stop_setfreq: assert property ($past(monitor_select_in) == 16'h0064 && $past(slot_out) == SLOT_FREQ
    && !$past(fault_in) && (!$past(running_in) || $past(output_shutoff_in))
    |-> front_panel_out.value == $past(meas_in.set_freq) && front_panel_out.hz_blink && !front_panel_out.hz_on)
    else $error("stop frequency wrong");
  a_run_outfreq: assert property ($past(monitor_select_in) == 16'h0064 && $past(slot_out) == SLOT_FREQ
    && !$past(fault_in) && $past(running_in) && !$past(output_shutoff_in)
    |-> front_panel_out.value == $past(meas_in.out_freq) && front_panel_out.hz_on)
    else $error("run frequency wrong");
  a_fault_hold: assert property ($past(fault_in, 3) && $past(fault_in, 2) && $past(fault_in)
    && $past(slot_out, 2) == SLOT_FREQ && $past(slot_out) == SLOT_FREQ |-> $stable(front_panel_out.value))
    else $error("fault frequency moved");
  a_hours_step: assert property (powered_hours_out != $past(powered_hours_out)
    |-> powered_hours_out == $past(powered_hours_out) + 16'h0001) else $error("hour step wrong");
  a_run_idle: assert property (run_hours_out != $past(run_hours_out) && run_hours_out != 16'h0000
    |-> $past(running_in)) else $error("run hours grew while stopped");
  a_run_clear: assert property (runtime_clear_wr_in && runtime_clear_in == 16'h0000
    |=> run_hours_out == 16'h0000) else $error("run hours not cleared");
  a_energy_clear: assert property (energy_clear_wr_in && energy_clear_in == 16'h0000
    |=> energy_raw_out == 40'h0) else $error("energy not cleared");
  a_energy_clamp: assert property (energy_digit_shift_in == 16'h0000 |-> energy_raw_out <= 40'd999999)
    else $error("energy above clamp");
endmodule : dmd_display_checker

bind dmd_display dmd_display_checker #(.SEC_CYC(SEC_CYC), .HOLD_CYC(HOLD_CYC)) u_checker (.clock_in, .nrst_in,
  .monitor_select_in, .energy_digit_shift_in, .energy_clear_wr_in, .energy_clear_in, .runtime_clear_wr_in,
  .runtime_clear_in, .running_in, .fault_in, .output_shutoff_in, .meas_in, .term_in, .front_panel_out,
  .slot_out, .current_mon_out, .power_mon_out, .powered_hours_out, .run_hours_out, .energy_raw_out);

/* test/dmd_panel_model.sv */
/*
  Operator panel model: presses and holds the set key.
  Assumes the display block samples the key on rising clock edges.
*/
`timescale 1ns/100ps
module dmd_panel_model (
  // Clock
  input  wire logic clock_in,
  // Key
  output logic      set_key_out
);
  initial set_key_out = 1'b0;

  // Hold the key for some cycles, then leave it idle until the slot settles
  task automatic press(input int cycles);
    @(negedge clock_in);
    set_key_out = 1'b1;
    repeat (cycles) @(negedge clock_in);
    set_key_out = 1'b0;
    repeat (4) @(negedge clock_in);
  endtask : press
endmodule : dmd_panel_model

/* test/dmd_display_bench.sv */
/*
  Self-checking bench for the monitor display select block.
  Assumes one second shortened to 10 cycles and a 5-cycle long press.
*/
`timescale 1ns/100ps
module dmd_display_bench;
  import dmd_pkg::*;
  localparam logic [27:0] G_SEGS = 28'h8102040;
  logic        clock_in = 1'b0;
  logic        nrst_in  = 1'b0;
  logic [15:0] sel      = 16'h0000;
  logic [15:0] shift    = 16'h0000;
  logic        ec_wr    = 1'b0;
  logic [15:0] ec       = 16'h0000;
  logic        rc_wr    = 1'b0;
  logic [15:0] rc       = 16'h0000;
  logic        running  = 1'b1;
  logic        fault    = 1'b0;
  logic        shutoff  = 1'b0;
  logic        key;
  dmd_meas_t   meas;
  dmd_term_t   term;
  dmd_disp_t   panel;
  dmd_slot_t   slot;
  logic [15:0] cur_mon;
  logic [15:0] pwr_mon;
  logic [15:0] pwr_hr;
  logic [15:0] run_hr;
  logic [15:0] comm;
  logic [39:0] raw;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc        = 0;

  dmd_display #(.SEC_CYC(10), .HOLD_CYC(5)) dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .monitor_select_in(sel), .energy_digit_shift_in(shift), .energy_clear_wr_in(ec_wr), .energy_clear_in(ec),
    .runtime_clear_wr_in(rc_wr), .runtime_clear_in(rc), .set_key_in(key), .running_in(running),
    .fault_in(fault), .output_shutoff_in(shutoff), .meas_in(meas), .term_in(term), .front_panel_out(panel),
    .slot_out(slot), .current_mon_out(cur_mon), .power_mon_out(pwr_mon), .powered_hours_out(pwr_hr),
    .run_hours_out(run_hr), .energy_raw_out(raw), .energy_comm_out(comm));
  dmd_panel_model u_panel (.clock_in(clock_in), .set_key_out(key));

  always #2 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic check_val(input string name, input logic [39:0] exp, input logic [39:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task automatic settle;
    repeat (2) @(negedge clock_in);
  endtask : settle

  task automatic clear_write(input logic energy, input logic [15:0] value);
    ec    = value;
    rc    = value;
    ec_wr = energy;
    rc_wr = !energy;
    @(negedge clock_in);
    ec_wr = 1'b0;
    rc_wr = 1'b0;
    settle();
  endtask : clear_write

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic t_freq;
    sel = 16'h0064;
    running = 1'b0;
    settle();
    check_val("stop freq", 16'h0100, panel.value);
    check_val("hz blink", 2'b01, {panel.hz_on, panel.hz_blink});
    running = 1'b1;
    settle();
    check_val("run freq", 16'h0200, panel.value);
    check_val("hz lit", 2'b10, {panel.hz_on, panel.hz_blink});
    shutoff = 1'b1;
    settle();
    check_val("shutoff freq", 16'h0100, panel.value);
    shutoff = 1'b0;
    sel = 16'h0000;
    fault = 1'b1;
    settle();
    meas.out_freq = 16'h0300;
    settle();
    check_val("fault freq", 16'h0200, panel.value);
    fault = 1'b0;
    settle();
    check_val("after fault", 16'h0300, panel.value);
  endtask : t_freq

  task automatic t_keys;
    u_panel.press(2);
    check_val("slot step", SLOT_CUR, slot);
    sel = 16'h0011;
    settle();
    check_val("load meter", 16'h0011, panel.value);
    sel = 16'h0000;
    u_panel.press(2);
    check_val("slot third", SLOT_VOLT, slot);
    u_panel.press(8);
    check_val("long hold", SLOT_VOLT, slot);
  endtask : t_keys

  task automatic t_hours;
    for (int i = 0; i < 40000 && run_hr !== 16'h0001; i++) @(negedge clock_in);
    check_val("run hours", 16'h0001, run_hr);
    check_val("powered hours", 16'h0001, pwr_hr);
    check_val("energy hour", 40'd100, raw);
    sel = 16'h0014;
    settle();
    check_val("hours panel", {4'h4, 16'h0000}, {panel.dp, panel.value});
    sel = 16'h0019;
    settle();
    check_val("energy panel", {4'h4, 16'd100}, {panel.dp, panel.value});
    shift = 16'h0002;
    settle();
    check_val("energy comm", 16'h0000, comm);
    check_val("energy shifted", {4'h4, 16'd1}, {panel.dp, panel.value});
    shift = 16'h270f;
    settle();
    check_val("wrap comm", 16'h0001, comm);
    shift = 16'h0000;
    clear_write(1'b0, 16'h270f);
    check_val("run kept", 16'h0001, run_hr);
    clear_write(1'b0, 16'h0000);
    check_val("run cleared", {16'h0000, 16'h0001}, {run_hr, pwr_hr});
    clear_write(1'b1, 16'h000a);
    check_val("energy kept", 40'd100, raw);
    clear_write(1'b1, 16'h0000);
    check_val("energy cleared", 40'h0, raw);
  endtask : t_hours

  task automatic t_third;
    sel = 16'h0011;
    settle();
    check_val("volt kept", 16'h00e6, panel.value);
    sel = 16'h0005;
    settle();
    check_val("ref freq", 16'h0258, panel.value);
    sel = 16'h000e;
    meas.power = 16'h2ee0;
    settle();
    check_val("dashes", 1'b1, panel.dashes);
    meas.power = 16'h270f;
    settle();
    check_val("four digits", {1'b0, 16'h270f}, {panel.dashes, panel.value});
    for (int s = 16'h0037; s <= 16'h0039; s++) begin
      sel = s[15:0];
      settle();
      check_val("term segs", {1'b1, G_SEGS}, {panel.seg_mode, panel.seg});
    end
    term = '1;
    term.opt_in_fit = 1'b0;
    term.opt_out_fit = 1'b0;
    sel = 16'h0038;
    settle();
    check_val("opt in absent", {4'h8, G_SEGS}, {panel.dp, panel.seg});
    sel = 16'h0039;
    settle();
    check_val("opt out absent", {4'h4, G_SEGS}, {panel.dp, panel.seg});
    term.unit_out = '0;
    sel = 16'h0037;
    settle();
    check_val("unit upper", 28'hc78f1e3, panel.seg);
    meas.current = 16'h0004;
    settle();
    check_val("cut off", 32'h0, {cur_mon, pwr_mon});
    meas.current = 16'h0005;
    settle();
    check_val("current", 16'h0005, cur_mon);
    meas.fault_code = 16'h0007;
    u_panel.press(2);
    check_val("fault slot", {SLOT_FAULT, 16'h0007}, {slot, panel.value});
  endtask : t_third

  initial begin
    meas = '0;
    meas.rated = 16'h0064;
    meas.current = 16'h0032;
    meas.power = 16'h0064;
    meas.set_freq = 16'h0100;
    meas.out_freq = 16'h0200;
    meas.volt = 16'h00e6;
    meas.ref_freq = 16'h0258;
    meas.load_meter = 16'h0011;
    term = '0;
    repeat (10) @(negedge clock_in);
    nrst_in = 1'b1;
    @(negedge clock_in);
    check_val("first slot", {SLOT_FREQ, 16'h0000}, {slot, pwr_hr});
    t_freq();
    t_keys();
    t_hours();
    t_third();
    finish_test();
  end
endmodule : dmd_display_bench
